// ### wdh_core.sv
// Watchdog counter with clock select, prescaler and halt wake-up control
// ----------------------------------------------------------------
// What this block does
// - While halted, wake on external reset, enabled pin fall, interrupt or overflow.
// - External reset wake gives full reset; watchdog wake gives watchdog reset.
// - Time-out and power-down flags are readable to identify the wake source.
// - Power-down flag cleared by power-up and clear-watchdog, set by halt.
// - Each wake-capable pin has an enable; enabled falling edge wakes the device.
// - Pin wake resumes after the halt instruction without reset.
// - Disabled or stack-full interrupt wake resumes; request stays pending.
// - Enabled interrupt with free stack level gets normal interrupt response.
// - A request already flagged at halt entry does not wake.
// - Wait 16 or 1024 clocks before resuming; external reset adds reset delay.
// - Reset delay after external reset is 100 ms.
// - Overflow while running resets the device and sets time-out flag.
// - Clock select: 00 slow RC, 01 system clock over four, 10 crystal.
// - System-clock-over-four source stops counting during halt.
// - Prescaler ratio is two to the power of the rate field.
// - Overflow while halted wakes, sets time-out, resets only PC and SP.
// - Counter cleared by low reset pin, clear-watchdog and halt.
// - Unimplemented prescale and clock select bits read zero.
// - Power-on reset raises neither sysResetOut nor pcSpReset; cpuRun starts high.
// - Reset pin low while running gives a normal-operation reset.
// - Halt sets power-down flag and clears time-out flag.
// - Halt clears counter; slow sources keep counting, system source stops.
// - Wake-time select clear gives 1024 clocks, set gives 16.
// ----------------------------------------------------------------
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module wdh_core
  import wdh_pkg::*;
#(
  parameter int unsigned WD_CNT_W        = 8,
  parameter int unsigned NUM_INT         = 4,
  parameter int unsigned RESET_DELAY_CYC = RESET_DELAY_CYC_DEF
)(
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic                extResetN,
  input  wire logic                slowRcClk,
  input  wire logic                xtalClk,
  input  wire wdh_pins_t           portPins,
  input  wire logic                haltExec,
  input  wire logic                clrWdtExec,
  input  wire logic [NUM_INT-1:0]  intReq,
  input  wire logic [NUM_INT-1:0]  intEnable,
  input  wire logic                stackFull,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [7:0]          regWrData,
  input  wire logic                regWrStb,
  input  wire logic                regRdStb,
  output logic [7:0]               regRdData,
  output logic                     sysResetOut,
  output logic                     pcSpReset,
  output logic                     cpuRun,
  output logic                     haltActive,
  output logic                     intServe,
  output logic                     timeoutFlag,
  output logic                     powerDownFlag
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (WD_CNT_W < 2 || NUM_INT < 1 || RESET_DELAY_CYC < 1 ||
      RESET_DELAY_CYC >= (64'h1 << DLY_W))
  begin : g_bad_param
    $error("wdh_core: unsupported parameter value");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    wdh_state_t            st;
    logic [6:0]            pre;
    logic [WD_CNT_W-1:0]   wd;
    logic [1:0]            div4;
    logic                  extS1;
    logic                  extS2;
    logic                  rcS1;
    logic                  rcS2;
    logic                  rcS3;
    logic                  xtS1;
    logic                  xtS2;
    logic                  xtS3;
    wdh_pins_t             pinS1;
    wdh_pins_t             pinS2;
    wdh_pins_t             pinS3;
    logic [2:0]            rate;
    logic [1:0]            csel;
    logic                  wts;
    logic [7:0]            wakeA;
    logic [7:0]            wakeB;
    logic [1:0]            wakeC;
    logic                  to;
    logic                  pwrDn;
    logic [NUM_INT-1:0]    intArm;
    logic                  serve;
    logic [DLY_W-1:0]      dly;
    logic                  sysRst;
    logic                  pcSp;
    logic                  run;
    logic                  halt;
    logic                  intSrv;
    logic [7:0]            rd;
  } wdh_reg_t;

  localparam wdh_reg_t S_INIT = '{st: ST_RUN, run: 1'b1, extS1: 1'b1, extS2: 1'b1,
                                  default: '0};

  wdh_reg_t            s_reg;
  wdh_reg_t            s_next;
  logic                extLow;
  logic                srcTick;
  logic                wdTick;
  logic                wdOvf;
  logic [6:0]          preMask;
  logic                pinWake;
  logic [NUM_INT-1:0]  intHit;
  logic                cfgClr;
  logic [DLY_W-1:0]    startupLoad;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next   = s_reg;
    cfgClr   = 1'b0;
    srcTick  = 1'b0;
    s_next.pcSp   = 1'b0;
    s_next.intSrv = 1'b0;
    s_next.rd     = 8'h00;

    // Pin synchronisers
    s_next.extS1  = extResetN;
    s_next.extS2  = s_reg.extS1;
    s_next.rcS1   = slowRcClk;
    s_next.rcS2   = s_reg.rcS1;
    s_next.rcS3   = s_reg.rcS2;
    s_next.xtS1   = xtalClk;
    s_next.xtS2   = s_reg.xtS1;
    s_next.xtS3   = s_reg.xtS2;
    s_next.pinS1  = portPins;
    s_next.pinS2  = s_reg.pinS1;
    s_next.pinS3  = s_reg.pinS2;
    extLow = ~s_reg.extS2;

    // Wake sources
    pinWake = |(s_reg.pinS3.portA & ~s_reg.pinS2.portA & s_reg.wakeA) |
              |(s_reg.pinS3.portB & ~s_reg.pinS2.portB & s_reg.wakeB) |
              |(s_reg.pinS3.portC & ~s_reg.pinS2.portC & s_reg.wakeC);
    intHit = intReq & s_reg.intArm;
    startupLoad = s_reg.wts ? DLY_W'(STARTUP_SHORT_CYC - 1)
                            : DLY_W'(STARTUP_LONG_CYC - 1);

    // Clock source select
    s_next.div4 = s_reg.div4 + 2'h1;
    unique case (s_reg.csel)
      CSEL_SLOWRC: srcTick = s_reg.rcS2 & ~s_reg.rcS3;
      CSEL_SYS4:   srcTick = (s_reg.div4 == 2'h3) && (s_reg.st != ST_HALT);
      CSEL_XTAL:   srcTick = s_reg.xtS2 & ~s_reg.xtS3;
      default:   srcTick = 1'b0;
    endcase

    // Prescaler and counter
    preMask = 7'((8'h01 << s_reg.rate) - 8'h01);
    wdTick  = srcTick && (s_reg.pre == preMask) &&
              (s_reg.st == ST_RUN || s_reg.st == ST_HALT);
    wdOvf   = wdTick && (&s_reg.wd);
    if (srcTick)
    begin
      s_next.pre = (s_reg.pre == preMask) ? 7'h00 : s_reg.pre + 7'h01;
    end
    if (wdTick)
    begin
      s_next.wd = s_reg.wd + 1'b1;
    end
    if (extLow || (s_reg.st == ST_RUN && (clrWdtExec || haltExec)))
    begin
      s_next.wd  = '0;
      s_next.pre = 7'h00;
    end

    // Register writes
    if (regWrStb)
    begin
      unique case (regAddr)
        OFF_PRESCALE: s_next.rate = regWrData[RATE_LSB +: 3];
        OFF_CLKSEL:   s_next.csel = regWrData[CSEL_LSB +: 2];
        OFF_SYSCTL:   s_next.wts  = regWrData[WTS_BIT];
        OFF_WAKE_A:   s_next.wakeA = regWrData;
        OFF_WAKE_B:   s_next.wakeB = regWrData;
        OFF_WAKE_C:   s_next.wakeC = regWrData[WAKE_C_LSB +: 2];
        default:      s_next.rd = 8'h00;
      endcase
    end

    // Register reads, answered in the next cycle
    if (regRdStb)
    begin
      unique case (regAddr)
        OFF_PRESCALE: s_next.rd = {5'h00, s_reg.rate};
        OFF_CLKSEL:   s_next.rd = {s_reg.csel, 6'h00};
        OFF_SYSCTL:   s_next.rd = {s_reg.wts, 7'h00};
        OFF_STATUS:   s_next.rd = {6'h00, s_reg.to, s_reg.pwrDn};
        OFF_WAKE_A:   s_next.rd = s_reg.wakeA;
        OFF_WAKE_B:   s_next.rd = s_reg.wakeB;
        OFF_WAKE_C:   s_next.rd = {5'h00, s_reg.wakeC, 1'b0};
        default:      s_next.rd = 8'h00;
      endcase
    end

    // Sequencer
    unique case (s_reg.st)
      ST_RUN:
      begin
        if (extLow)
        begin
          s_next.st     = ST_HOLD;
          s_next.sysRst = 1'b1;
          s_next.run    = 1'b0;
        end
        else if (wdOvf)
        begin
          s_next.to     = 1'b1;
          s_next.st     = ST_RSTDLY;
          s_next.dly    = DLY_W'(RESET_DELAY_CYC - 1);
          s_next.sysRst = 1'b1;
          s_next.run    = 1'b0;
          cfgClr        = 1'b1;
        end
        else if (haltExec)
        begin
          s_next.st     = ST_HALT;
          s_next.pwrDn  = 1'b1;
          s_next.to     = 1'b0;
          s_next.intArm = ~intReq;
          s_next.halt   = 1'b1;
          s_next.run    = 1'b0;
        end
        else if (clrWdtExec)
        begin
          s_next.pwrDn = 1'b0;
        end
      end
      ST_HALT:
      begin
        if (extLow)
        begin
          s_next.st     = ST_HOLD;
          s_next.sysRst = 1'b1;
          s_next.halt   = 1'b0;
        end
        else if (wdOvf)
        begin
          s_next.to    = 1'b1;
          s_next.pcSp  = 1'b1;
          s_next.serve = 1'b0;
          s_next.st    = ST_STARTUP;
          s_next.dly   = startupLoad;
          s_next.halt  = 1'b0;
        end
        else if (pinWake)
        begin
          s_next.serve = 1'b0;
          s_next.st    = ST_STARTUP;
          s_next.dly   = startupLoad;
          s_next.halt  = 1'b0;
        end
        else if (|intHit)
        begin
          s_next.serve = (|(intHit & intEnable)) & ~stackFull;
          s_next.st    = ST_STARTUP;
          s_next.dly   = startupLoad;
          s_next.halt  = 1'b0;
        end
      end
      ST_HOLD:
      begin
        cfgClr        = 1'b1;
        s_next.sysRst = 1'b1;
        if (!extLow)
        begin
          s_next.st  = ST_RSTDLY;
          s_next.dly = DLY_W'(RESET_DELAY_CYC - 1);
        end
      end
      ST_RSTDLY:
      begin
        if (extLow)
        begin
          s_next.st = ST_HOLD;
        end
        else if (s_reg.dly == '0)
        begin
          s_next.st  = ST_STARTUP;
          s_next.dly = startupLoad;
        end
        else
        begin
          s_next.dly = s_reg.dly - 1'b1;
        end
      end
      ST_STARTUP:
      begin
        if (extLow)
        begin
          s_next.st     = ST_HOLD;
          s_next.sysRst = 1'b1;
        end
        else if (s_reg.dly == '0)
        begin
          s_next.st     = ST_RUN;
          s_next.run    = 1'b1;
          s_next.sysRst = 1'b0;
          s_next.intSrv = s_reg.serve;
          s_next.serve  = 1'b0;
        end
        else
        begin
          s_next.dly = s_reg.dly - 1'b1;
        end
      end
      default:
      begin
        s_next.st = ST_HOLD;
      end
    endcase

    if (cfgClr)
    begin
      s_next.rate  = 3'h0;
      s_next.csel  = CSEL_SLOWRC;
      s_next.wts   = 1'b0;
      s_next.wakeA = REG_RESET;
      s_next.wakeB = REG_RESET;
      s_next.wakeC = 2'h0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_reg <= S_INIT;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign regRdData     = s_reg.rd;
  assign sysResetOut   = s_reg.sysRst;
  assign pcSpReset     = s_reg.pcSp;
  assign cpuRun        = s_reg.run;
  assign haltActive    = s_reg.halt;
  assign intServe      = s_reg.intSrv;
  assign timeoutFlag   = s_reg.to;
  assign powerDownFlag = s_reg.pwrDn;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [10:0] stCyc;

  always_ff @(posedge ref_clk)
  begin
    if (reset || s_reg.st != ST_STARTUP)
    begin
      stCyc <= 11'h000;
    end
    else
    begin
      stCyc <= stCyc + 11'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_halt_flags: assert property (
    s_reg.st == ST_RUN && s_reg.extS2 && !wdOvf && haltExec
    |=> powerDownFlag && !timeoutFlag && haltActive && !cpuRun)
    else $error("halt entry flags wrong");

  a_clr_pwrdn: assert property (
    s_reg.st == ST_RUN && s_reg.extS2 && !wdOvf && clrWdtExec && !haltExec
    |=> !powerDownFlag)
    else $error("clear-watchdog left power-down flag set");

  a_wd_clear: assert property (
    !s_reg.extS2 || (s_reg.st == ST_RUN && (clrWdtExec || haltExec))
    |=> s_reg.wd == '0)
    else $error("watchdog counter not cleared");

  a_halt_wdt_wake: assert property (
    s_reg.st == ST_HALT && s_reg.extS2 && wdOvf
    |=> pcSpReset && timeoutFlag && !sysResetOut ##1 !pcSpReset)
    else $error("halted overflow wake wrong");

  a_port_wake: assert property (
    s_reg.st == ST_HALT && s_reg.extS2 && !wdOvf && pinWake
    |=> s_reg.st == ST_STARTUP && !sysResetOut && !pcSpReset)
    else $error("pin wake wrong");

  a_armed_int: assert property (
    s_reg.st == ST_HALT && s_reg.extS2 && !wdOvf && !pinWake
    && (intReq & s_reg.intArm) == '0
    |=> s_reg.st == ST_HALT)
    else $error("unexpected wake");

  a_startup_len: assert property (
    s_reg.st == ST_STARTUP && s_next.st == ST_RUN
    |-> stCyc == (s_reg.wts ? 11'h00f : 11'h3ff))
    else $error("start-up delay length wrong");

  a_normal_timeout: assert property (
    s_reg.st == ST_RUN && s_reg.extS2 && wdOvf
    |=> sysResetOut && timeoutFlag && !cpuRun)
    else $error("running overflow did not reset");

  a_clksel_zero: assert property (
    regRdStb && regAddr == OFF_CLKSEL |=> regRdData[5:0] == 6'h00)
    else $error("clock select reserved bits not zero");

  a_sys4_halt: assert property (
    s_reg.st == ST_HALT && s_reg.csel == CSEL_SYS4 && s_reg.extS2
    |=> $stable(s_reg.wd))
    else $error("counter moved in halt on system source");

  a_ext_reset: assert property (
    s_reg.st == ST_HALT && !s_reg.extS2 |=> sysResetOut && s_reg.st == ST_HOLD)
    else $error("external reset wake not full reset");

endmodule

`default_nettype wire

// ### wdh_pkg.sv
// Package: constants and types of the watchdog and halt wake-up block
package wdh_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 3;
  localparam logic [2:0]  OFF_PRESCALE = 3'h0;
  localparam logic [2:0]  OFF_CLKSEL   = 3'h1;
  localparam logic [2:0]  OFF_SYSCTL   = 3'h2;
  localparam logic [2:0]  OFF_STATUS   = 3'h3;
  localparam logic [2:0]  OFF_WAKE_A   = 3'h4;
  localparam logic [2:0]  OFF_WAKE_B   = 3'h5;
  localparam logic [2:0]  OFF_WAKE_C   = 3'h6;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned RATE_LSB     = 0;
  localparam int unsigned CSEL_LSB     = 6;
  localparam int unsigned WTS_BIT      = 7;
  localparam int unsigned STAT_PDN_BIT = 0;
  localparam int unsigned STAT_TO_BIT  = 1;
  localparam int unsigned WAKE_C_LSB   = 1;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [1:0]  CSEL_SLOWRC  = 2'h0;
  localparam logic [1:0]  CSEL_SYS4    = 2'h1;
  localparam logic [1:0]  CSEL_XTAL    = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ              = 200_000_000;
  localparam int unsigned RESET_DELAY_MS      = 100;
  localparam int unsigned RESET_DELAY_CYC_DEF = CLK_HZ / 1000 * RESET_DELAY_MS;
  localparam int unsigned STARTUP_SHORT_CYC   = 16;
  localparam int unsigned STARTUP_LONG_CYC    = 1024;
  localparam int unsigned DLY_W               = 25;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_HALT    = 3'b001,
    ST_HOLD    = 3'b010,
    ST_RSTDLY  = 3'b011,
    ST_STARTUP = 3'b100
  } wdh_state_t;

  typedef struct packed {
    logic [7:0] portA;
    logic [7:0] portB;
    logic [1:0] portC;
  } wdh_pins_t;

endpackage

// ### wdh_cpu_model.sv
// Processor core model: interrupt request flags
`timescale 1ns/10ps
`default_nettype none
module wdh_cpu_model
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       sysResetOut,
  input  wire logic       intServe,
  input  wire logic [3:0] intEnable,
  input  wire logic [3:0] raiseInt,
  output logic [3:0]      intReq
);
  // Served flags clear, unserved flags stay pending
  always @(posedge ref_clk)
  begin
    if (reset || sysResetOut)
      intReq <= 4'h0;
    else
      intReq <= (intReq | raiseInt) & ~(intServe ? intEnable : 4'h0);
  end
endmodule
`default_nettype wire

// ### tb_watchdog_halt_wakeup.sv
// Testbench of the watchdog and halt wake-up block
`timescale 1ns/10ps
`default_nettype none
module tb_watchdog_halt_wakeup
  import wdh_pkg::*;
;
  logic       ref_clk = 0, reset = 1, extResetN = 1, slowClk = 0;
  logic       rcOn = 0, xtOn = 0, haltExec = 0, clrWdtExec = 0;
  logic       stackFull = 0, regWrStb = 0, regRdStb = 0;
  logic [3:0] intEnable = 0, raiseInt = 0, intReq;
  logic [2:0] regAddr = 0;
  logic [7:0] regWrData = 0, regRdData;
  logic       sysResetOut, pcSpReset, cpuRun, haltActive, intServe;
  logic       timeoutFlag, powerDownFlag, sawPcSp = 0, sawServe = 0;
  wdh_pins_t  portPins = '1;
  int         miscompares = 0, cmpCount = 0, cycles = 0, n, i;
  wire logic  slowRcClk = slowClk & rcOn;
  wire logic  xtalClk = slowClk & xtOn;

  always #2.5 ref_clk = ~ref_clk;
  always #50 slowClk = ~slowClk;

  wdh_core #(.WD_CNT_W(2), .NUM_INT(4), .RESET_DELAY_CYC(8)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .extResetN(extResetN),
    .slowRcClk(slowRcClk), .xtalClk(xtalClk), .portPins(portPins),
    .haltExec(haltExec), .clrWdtExec(clrWdtExec), .intReq(intReq),
    .intEnable(intEnable), .stackFull(stackFull), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .sysResetOut(sysResetOut), .pcSpReset(pcSpReset),
    .cpuRun(cpuRun), .haltActive(haltActive), .intServe(intServe),
    .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag));

  wdh_cpu_model u_cpu (
    .ref_clk(ref_clk), .reset(reset), .sysResetOut(sysResetOut),
    .intServe(intServe), .intEnable(intEnable), .raiseInt(raiseInt),
    .intReq(intReq));

  task summarize;
    $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask

  task rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    check(regRdData, exp);
  endtask

  task instr(input bit h);
    @(posedge ref_clk);
    if (h)
      haltExec <= 1'b1;
    else
      clrWdtExec <= 1'b1;
    @(posedge ref_clk);
    haltExec <= 1'b0;
    clrWdtExec <= 1'b0;
    #1;
  endtask

  task raise(input logic [3:0] b);
    @(posedge ref_clk);
    raiseInt <= b;
    @(posedge ref_clk);
    raiseInt <= 4'h0;
  endtask

  task automatic waitFor(input bit rst, output int n);
    int t0;
    t0 = -1;
    n = -1;
    for (int k = 0; k < 1200; k++)
    begin
      @(posedge ref_clk);
      #1;
      if (t0 < 0 && (rst || haltActive === 1'b0))
        t0 = k;
      if ((rst ? sysResetOut : cpuRun) === 1'b1)
      begin
        n = k - t0;
        break;
      end
    end
  endtask

  task pinWake;
    @(posedge ref_clk);
    portPins.portA[0] <= 1'b0;
    waitFor(0, n);
    check(8'(n), 8'h10);
    @(posedge ref_clk);
    portPins.portA[0] <= 1'b1;
  endtask

  always @(negedge ref_clk)
  begin
    cycles++;
    if (pcSpReset)
      sawPcSp = 1;
    if (intServe)
      sawServe = 1;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    for (i = 0; i < 8; i++)
      rd(3'(i), REG_RESET);
    wr(OFF_PRESCALE, 8'hff);
    wr(OFF_CLKSEL, 8'hff);
    wr(OFF_STATUS, 8'hff);
    rd(OFF_PRESCALE, 8'h07);
    rd(OFF_CLKSEL, 8'hc0);
    rd(OFF_STATUS, 8'h00);
    // Pin wake, short start-up
    wr(OFF_SYSCTL, 8'h80);
    wr(OFF_WAKE_A, 8'h01);
    instr(1);
    check(8'({haltActive, cpuRun, powerDownFlag, timeoutFlag}), 8'h0a);
    rd(OFF_STATUS, 8'h01);
    pinWake();
    check(8'({sawPcSp, sysResetOut}), 8'h00);
    instr(0);
    rd(OFF_STATUS, 8'h00);
    // Served interrupt wake
    @(posedge ref_clk);
    intEnable <= 4'h1;
    instr(1);
    raise(4'h1);
    waitFor(0, n);
    check(8'(intServe), 8'h01);
    // Disabled, then stack-full interrupt wake
    for (i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      intEnable <= 4'(i * 4);
      stackFull <= i[0];
      sawServe = 0;
      instr(1);
      raise(4'h2 << i);
      waitFor(0, n);
      check(8'({sawServe | intServe, intReq[i+1], cpuRun}), 8'h03);
    end
    // Flag set at entry and disabled pin do not wake
    @(posedge ref_clk);
    stackFull <= 1'b0;
    instr(1);
    raise(4'h2);
    portPins.portB[0] <= 1'b0;
    repeat (40) @(posedge ref_clk);
    #1;
    check(8'(haltActive), 8'h01);
    @(posedge ref_clk);
    portPins.portB[0] <= 1'b1;
    pinWake();
    // Halted overflow from slow RC, then crystal
    for (i = 0; i < 2; i++)
    begin
      wr(OFF_PRESCALE, 8'h00);
      wr(OFF_CLKSEL, i ? 8'h80 : 8'h00);
      sawPcSp = 0;
      instr(1);
      @(posedge ref_clk);
      rcOn <= (i == 0);
      xtOn <= (i == 1);
      waitFor(0, n);
      check(8'({sawPcSp, sysResetOut}), 8'h02);
      check(8'(n), 8'h10);
      @(posedge ref_clk);
      rcOn <= 1'b0;
      xtOn <= 1'b0;
      rd(OFF_STATUS, 8'h03);
      rd(OFF_SYSCTL, 8'h80);
    end
    // System clock source stops during halt
    wr(OFF_PRESCALE, 8'h07);
    wr(OFF_CLKSEL, 8'h40);
    sawPcSp = 0;
    instr(1);
    repeat (2200) @(posedge ref_clk);
    check(8'({sawPcSp, haltActive}), 8'h01);
    pinWake();
    // Running overflow time follows the rate field
    for (i = 1; i < 4; i += 2)
    begin
      wr(OFF_PRESCALE, 8'(i));
      wr(OFF_CLKSEL, 8'h40);
      instr(0);
      waitFor(1, n);
      check(8'((n >= (12 << i) - 4) && (n <= (16 << i) + 8)), 8'h01);
      check(8'(timeoutFlag), 8'h01);
      waitFor(0, n);
      rd(OFF_PRESCALE, 8'h00);
      rd(OFF_STATUS, 8'h02);
    end
    // External reset while halted
    instr(1);
    @(posedge ref_clk);
    extResetN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check(8'({sysResetOut, cpuRun}), 8'h02);
    @(posedge ref_clk);
    extResetN <= 1'b1;
    waitFor(0, n);
    check(8'((n >= 1032) && (n <= 1040)), 8'h01);
    check(8'(sysResetOut), 8'h00);
    rd(OFF_STATUS, 8'h01);
    summarize();
  end
endmodule
`default_nettype wire
